/* hw/rpc_top.sv */
`timescale 1ns/1ns


// output buffer: flip-flop storage, valid/ready on both sides
module rpc_fifo #(
  parameter int unsigned WIDTH = rpc_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = rpc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         ce_i,
  input  wire logic                         flush_i,
  // fill side
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [WIDTH-1:0]             in_data_i,
  // drain side
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [WIDTH-1:0]                  out_data_o,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]        level_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);
  // whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage entries
    logic [AW-1:0]               wr;    // write index
    logic [AW-1:0]               rd;    // read index
    logic [CW-1:0]               cnt;   // words held
  } rpc_fifo_s;
  rpc_fifo_s st;        // registered state
  rpc_fifo_s next_st;   // next state
  logic      do_wr;     // word taken in
  logic      do_rd;     // word handed out
  // honest full and empty from the word count
  assign in_ready_o  = (st.cnt != CW'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = st.mem[st.rd];
  assign level_o     = st.cnt;
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;
  // next-state logic: pointers wrap at depth
  always_comb
  begin
    next_st = st;
    if (do_wr)
    begin
      next_st.mem[st.wr] = in_data_i;
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + AW'(1);
    end
    if (do_rd)
    begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + AW'(1);
    end
    // count nets both sides, unchanged when both act at once
    next_st.cnt = st.cnt + CW'(do_wr) - CW'(do_rd);
    // end of block empties the buffer
    if (flush_i)
    begin
      next_st.wr  = '0;
      next_st.rd  = '0;
      next_st.cnt = '0;
    end
  end

  // state register, frozen while enable low
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

endmodule

// read-path error classifier, lock generator and tape mark detector
module rpc_top #(
  parameter int unsigned DELAY = rpc_pkg::DELAY_CHARS,
  parameter int unsigned LOCKN = rpc_pkg::LOCK_CHARS,
  parameter int unsigned DEPTH = rpc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic       CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       CE_I,
  // read control
  input  wire logic       READ_ENABLE_IN_I,
  input  wire logic       HIGH_SPEED_I,
  // character from the deskew stages
  input  wire logic       CHAR_STROBE_I,
  output logic            CHAR_READY_O,
  input  wire logic [8:0] TRACK_DATA_I,
  input  wire logic [8:0] TRACK_ERROR_FLAG_I,
  input  wire logic [8:0] TRACK_QUIET_I,
  input  wire logic [8:0] ZERO_DETECT_I,
  input  wire logic [8:0] ONE_DETECT_I,
  // correction back to the read stages
  output logic            PARITY_SUBSTITUTE_BIT_O,
  output logic [8:0]      SUBSTITUTE_SELECT_O,
  output logic            LOCK_O,
  // formatter interface data
  output logic            DATA_VALID_O,
  input  wire logic       DATA_READY_I,
  output logic [8:0]      DATA_O,
  // formatter interface flags
  output logic            HARD_ERROR_OUT_O,
  output logic            CORRECTABLE_ERROR_OUT_O,
  output logic            TAPE_MARK_TO_INTERFACE_O,
  // control microprocessor flag
  output logic            TAPE_MARK_TO_CPU_O
);

  localparam int unsigned LW = $clog2(LOCKN+1);
  localparam int unsigned FW = $clog2(DEPTH+1);

  // whole block state
  typedef struct packed {
    logic                  read_enable_in;        // read enable, last cycle
    logic                  lock;        // sync lock level
    logic [LW-1:0]         lock_cnt;    // valid characters seen
    logic [DELAY-1:0][8:0] dly_data;    // delayed characters
    logic [DELAY-1:0]      dly_vld;     // stage holds a character
    logic [DELAY-1:0]      dly_par;     // delayed parity failure
    logic [DELAY-1:0]      dly_cor;     // delayed correctable mark
    logic                  char_ready;  // room for a character
    logic                  hard;        // hard error flag
    logic                  corr;        // correctable error flag
    logic                  tm_if;       // tape mark, interface
    logic                  tm_cpu;      // tape mark, cpu
    logic                  sub_bit;     // substitute bit
    logic [8:0]            sub_sel;     // channel receiving it
    logic                  out_valid;   // output stage full
    logic [8:0]            out_data;    // output stage word
  } rpc_state_s;
  rpc_state_s st;        // registered state
  rpc_state_s next_st;   // next state
  // character classification
  logic       advance;      // character accepted this cycle
  logic       any_err;      // at least one track in error
  logic       multi_err;    // two or more tracks in error
  logic       single_err;   // exactly one track in error
  logic       valid_char;   // eight or more good tracks
  logic       multi_track_error; // immediate multi-channel hard error
  logic       sub_bit;      // regenerated parity for failing track
  logic [8:0] fixed_data;   // character after substitution
  logic       parity_fail;  // even parity over fixed character
  logic       all_zero_detect; // combined zero detect
  logic       all_one_detect;  // combined one detect
  logic       tm_pattern;   // tape mark track pattern
  logic       tm_lo;        // low-speed tape mark path
  logic       tm_hi;        // high-speed tape mark path
  logic       read_start;   // read enable rising edge
  logic       rd_stop;      // read enable low
  // pipeline shift inputs, one per stage
  logic [DELAY-1:0][8:0] shift_data;
  logic [DELAY-1:0]      shift_vld;
  logic [DELAY-1:0]      shift_par;
  logic [DELAY-1:0]      shift_cor;
  // buffer handshakes
  logic          fifo_in_ready;  // buffer has room
  logic          fifo_out_valid; // buffer holds a word
  logic          fifo_out_ready; // output stage can take a word
  logic [8:0]    fifo_out_data;  // word leaving buffer
  logic [FW-1:0] fifo_level;     // words in buffer
  logic          fifo_push;      // delayed character leaves pipe
  // a character is taken only while the buffer has room
  assign advance = CHAR_STROBE_I & st.char_ready & fifo_in_ready;
  // error count reduced to none, one, or more without a popcount
  assign any_err    = |TRACK_ERROR_FLAG_I;
  assign multi_err  = |(TRACK_ERROR_FLAG_I & (TRACK_ERROR_FLAG_I - 9'h001));
  assign single_err = any_err & ~multi_err;
  assign valid_char = ~multi_err;
  // immediate hard error, held off until lock drops
  assign multi_track_error = multi_err & ~st.lock;
  // parity of the eight good tracks, inverted, keeps odd parity
  assign sub_bit = ~(^(TRACK_DATA_I & ~TRACK_ERROR_FLAG_I));
  // failing channel takes the regenerated bit
  assign fixed_data = single_err ?
                      ((TRACK_DATA_I & ~TRACK_ERROR_FLAG_I) |
                       (TRACK_ERROR_FLAG_I & {9{sub_bit}})) :
                      TRACK_DATA_I;
  // even parity means the character is bad
  assign parity_fail = ~(^fixed_data);
  // combined detects across all nine channels
  assign all_zero_detect = &ZERO_DETECT_I;
  assign all_one_detect  = &ONE_DETECT_I;
  // zeros on the mark tracks, nothing recorded elsewhere
  assign tm_pattern = ((TRACK_DATA_I & rpc_pkg::TM_ZERO_TRACKS) == 9'h000) &
                      ((TRACK_QUIET_I & rpc_pkg::TM_ZERO_TRACKS) == 9'h000) &
                      ((TRACK_QUIET_I | rpc_pkg::TM_ZERO_TRACKS) == 9'h1FF);
  // qualified pattern gated through the path for the current speed
  assign tm_lo = tm_pattern & all_zero_detect & ~all_one_detect & ~HIGH_SPEED_I;
  assign tm_hi = tm_pattern & all_zero_detect & ~all_one_detect & HIGH_SPEED_I;
  // read operation boundaries
  assign read_start = READ_ENABLE_IN_I & ~st.read_enable_in;
  assign rd_stop    = ~READ_ENABLE_IN_I;
  // delay line taps: stage 0 takes the new character
  genvar g;
  generate
    for (g = 0; g < DELAY; g++)
    begin : g_stage
      if (g == 0)
      begin : g_head
        assign shift_data[g] = fixed_data;
        assign shift_vld[g]  = 1'b1;
        assign shift_par[g]  = parity_fail & ~single_err & ~st.lock;
        assign shift_cor[g]  = single_err & ~st.lock;
      end
      else
      begin : g_body
        assign shift_data[g] = st.dly_data[g-1];
        assign shift_vld[g]  = st.dly_vld[g-1];
        assign shift_par[g]  = st.dly_par[g-1];
        assign shift_cor[g]  = st.dly_cor[g-1];
      end
    end
  endgenerate

  // oldest stage is pushed once the pipe has filled
  assign fifo_push      = advance & st.dly_vld[DELAY-1];
  assign fifo_out_ready = ~st.out_valid | DATA_READY_I;

  // output buffer between the delay line and the interface
  rpc_fifo #(
    .WIDTH (rpc_pkg::FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rstn_i      (RSTN_I),
    .ce_i        (CE_I),
    .flush_i     (rd_stop),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (st.dly_data[DELAY-1]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // next-state logic for lock, pipelines, flags and output stage
  always_comb
  begin
    next_st      = st;
    next_st.read_enable_in = READ_ENABLE_IN_I;
    // stall the source one word before the buffer fills
    next_st.char_ready = (fifo_level < FW'(DEPTH-1));
    // tape mark flags are one-cycle pulses
    next_st.tm_if  = 1'b0;
    next_st.tm_cpu = 1'b0;
    // new read: lock on, counter cleared
    if (read_start)
    begin
      next_st.lock     = rpc_pkg::LOCK_RESET;
      next_st.lock_cnt = '0;
    end
    // a taken character during a read
    if (advance & READ_ENABLE_IN_I)
    begin
      // lock counter runs once per valid character
      if (st.lock & valid_char)
      begin
        next_st.lock_cnt = st.lock_cnt + LW'(1);
        if (st.lock_cnt == LW'(LOCKN-1))
        begin
          next_st.lock = 1'b0;
        end
      end
      // shift the delay line one character
      next_st.dly_data = shift_data;
      next_st.dly_vld  = shift_vld;
      next_st.dly_par  = shift_par;
      next_st.dly_cor  = shift_cor;
      // hard: immediate multi-channel OR delayed parity failure
      next_st.hard = multi_track_error | st.dly_par[DELAY-1];
      // correctable flag lines up with its delayed character
      next_st.corr = st.dly_cor[DELAY-1];
      // correction drive back to the failing read stage
      next_st.sub_bit = sub_bit;
      next_st.sub_sel = (single_err & ~st.lock) ?
                        TRACK_ERROR_FLAG_I : 9'h000;
      // tape mark to both parties
      next_st.tm_if  = tm_lo | tm_hi;
      next_st.tm_cpu = tm_lo | tm_hi;
    end
    // output stage pulls from the buffer
    if (fifo_out_ready)
    begin
      next_st.out_valid = fifo_out_valid;
      if (fifo_out_valid)
      begin
        next_st.out_data = fifo_out_data;
      end
    end
    // end of block: lock, delay line flags, error flags, select and output stage back to their initial state
    if (rd_stop)
    begin
      next_st.lock      = rpc_pkg::LOCK_RESET;
      next_st.lock_cnt  = '0;
      next_st.dly_vld   = '0;
      next_st.dly_par   = '0;
      next_st.dly_cor   = '0;
      next_st.hard      = rpc_pkg::FLAG_RESET;
      next_st.corr      = rpc_pkg::FLAG_RESET;
      next_st.sub_sel   = rpc_pkg::WORD_RESET;
      next_st.out_valid = 1'b0;
    end
  end

  // state register, frozen while enable low
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      st            <= '0;
      st.lock       <= rpc_pkg::LOCK_RESET;
      st.char_ready <= rpc_pkg::READY_RESET;
    end
    else if (CE_I)
    begin
      st <= next_st;
    end
  end

  // outputs straight from state flip-flops
  assign CHAR_READY_O             = st.char_ready;
  assign PARITY_SUBSTITUTE_BIT_O  = st.sub_bit;
  assign SUBSTITUTE_SELECT_O      = st.sub_sel;
  assign LOCK_O                   = st.lock;
  assign DATA_VALID_O             = st.out_valid;
  assign DATA_O                   = st.out_data;
  assign HARD_ERROR_OUT_O         = st.hard;
  assign CORRECTABLE_ERROR_OUT_O  = st.corr;
  assign TAPE_MARK_TO_INTERFACE_O = st.tm_if;
  assign TAPE_MARK_TO_CPU_O       = st.tm_cpu;

endmodule

/* pkg/rpc_pkg.sv */
package rpc_pkg;

  // track layout: bits 0..7 are data tracks, bit 8 is the parity track
  localparam int unsigned NUM_TRACKS  = 9;
  localparam int unsigned PARITY_BIT  = 8;

  // tape mark pattern: tracks carrying zeros, all others quiet
  localparam logic [8:0]  TM_ZERO_TRACKS = 9'h0C4;

  // characters of data delay between deskew output and interface
  localparam int unsigned DELAY_CHARS = 8;

  // valid characters needed before the lock signal drops
  localparam int unsigned LOCK_CHARS  = 8;

  // output buffer size in characters
  localparam int unsigned FIFO_DEPTH  = 32;

  // width of one buffered word (the character itself)
  localparam int unsigned FIFO_WIDTH  = 9;

  // reset values of control state
  localparam logic        LOCK_RESET  = 1'b1;
  localparam logic        FLAG_RESET  = 1'b0;
  localparam logic        READY_RESET = 1'b0;
  localparam logic [8:0]  WORD_RESET  = 9'h000;

endpackage

/* test/rpc_chk.sv */
`timescale 1ns/1ns

// concurrent checks on the classifier ports
module rpc_chk (
  // clock, reset, control
  input wire logic       CLK_I,
  input wire logic       RSTN_I,
  input wire logic       CE_I,
  input wire logic       READ_ENABLE_IN_I,
  // character input
  input wire logic       CHAR_STROBE_I,
  input wire logic       CHAR_READY_O,
  input wire logic [8:0] TRACK_DATA_I,
  input wire logic [8:0] TRACK_ERROR_FLAG_I,
  input wire logic [8:0] TRACK_QUIET_I,
  input wire logic [8:0] ZERO_DETECT_I,
  input wire logic [8:0] ONE_DETECT_I,
  // results
  input wire logic       PARITY_SUBSTITUTE_BIT_O,
  input wire logic [8:0] SUBSTITUTE_SELECT_O,
  input wire logic       LOCK_O,
  input wire logic       DATA_VALID_O,
  input wire logic       HARD_ERROR_OUT_O,
  input wire logic       CORRECTABLE_ERROR_OUT_O,
  input wire logic       TAPE_MARK_TO_INTERFACE_O,
  input wire logic       TAPE_MARK_TO_CPU_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // character accepted at this edge
  logic       taken;
  // number of failing tracks
  logic [3:0] nerr;
  // tape mark pattern on the inputs
  logic       tm;
  // inverted parity of the good tracks
  logic       other_par;
  assign taken = CE_I && CHAR_STROBE_I && CHAR_READY_O && READ_ENABLE_IN_I;
  assign nerr = 4'($countones(TRACK_ERROR_FLAG_I));
  assign other_par = ~^(TRACK_DATA_I & ~TRACK_ERROR_FLAG_I);
  assign tm = (((TRACK_DATA_I | TRACK_QUIET_I) & rpc_pkg::TM_ZERO_TRACKS) == 9'h000)
    && ((TRACK_QUIET_I | rpc_pkg::TM_ZERO_TRACKS) == 9'h1FF)
    && (&ZERO_DETECT_I) && !(&ONE_DETECT_I);

  AST_RESET_STATE: assert property (disable iff (1'b0)
    !RSTN_I && CE_I |=> LOCK_O && !DATA_VALID_O && !HARD_ERROR_OUT_O)
    else $error("outputs not cleared by reset");
  AST_REN_CLEAR: assert property (
    CE_I && !READ_ENABLE_IN_I |=> LOCK_O && !HARD_ERROR_OUT_O && !CORRECTABLE_ERROR_OUT_O)
    else $error("read enable low did not clear");
  AST_LOCKED_QUIET: assert property (
    taken && LOCK_O |=> !CORRECTABLE_ERROR_OUT_O && !HARD_ERROR_OUT_O
      && SUBSTITUTE_SELECT_O == 9'h000)
    else $error("error flag while locked");
  AST_MULTI_HARD: assert property (
    taken && !LOCK_O && nerr > 4'h1 |=> HARD_ERROR_OUT_O)
    else $error("multi track error without hard flag");
  AST_SINGLE_SELECT: assert property (
    taken && !LOCK_O && nerr == 4'h1 |=> SUBSTITUTE_SELECT_O == $past(TRACK_ERROR_FLAG_I))
    else $error("wrong substitute channel");
  AST_SUBST_BIT: assert property (
    taken && !LOCK_O && nerr == 4'h1 |=> PARITY_SUBSTITUTE_BIT_O == $past(other_par))
    else $error("wrong substitute bit");
  AST_LOCK_HOLD: assert property (
    LOCK_O && !(taken && nerr < 4'h2) |=> LOCK_O)
    else $error("lock dropped without valid character");
  AST_TM_RAISE: assert property (
    taken && tm |=> TAPE_MARK_TO_INTERFACE_O && TAPE_MARK_TO_CPU_O)
    else $error("tape mark missed");
  AST_TM_QUALIFY: assert property (
    !(taken && tm) |=> !TAPE_MARK_TO_INTERFACE_O && !TAPE_MARK_TO_CPU_O)
    else $error("tape mark without pattern");

  // main scenarios reached
  COV_TAPE_MARK: cover property (TAPE_MARK_TO_CPU_O);
  COV_CORRECT: cover property (CORRECTABLE_ERROR_OUT_O);
  COV_LOCK_DONE: cover property ($fell(LOCK_O));
  COV_FULL: cover property (READ_ENABLE_IN_I && !CHAR_READY_O);
endmodule

bind rpc_top rpc_chk rpc_chk_i (.*);

/* test/rpc_fmt_model.sv */
`timescale 1ns/1ns

// formatter and cpu side: drains words, stalls on command, counts marks
module rpc_fmt_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // stall controls from the bench
  input  wire logic stall_i,
  input  wire logic slow_i,
  // word handshake
  output logic      ready_o,
  // tape mark flags
  input  wire logic tm_if_i,
  input  wire logic tm_cpu_i,
  // mark counts seen
  output int        marks_if_o,
  output int        marks_cpu_o
);
  // toggles to pace slow draining
  logic pace;
  initial
  begin
    pace = 1'b0;
    ready_o = 1'b0;
    marks_if_o = 0;
    marks_cpu_o = 0;
  end
  // ready moves only at the falling edge
  always @(negedge clk_i)
  begin
    pace <= ~pace;
    ready_o <= rstn_i && !stall_i && (!slow_i || pace);
  end
  // both flags counted at the sampling edge
  always @(posedge clk_i)
  begin
    if (tm_if_i === 1'b1)
      marks_if_o <= marks_if_o + 1;
    if (tm_cpu_i === 1'b1)
      marks_cpu_o <= marks_cpu_o + 1;
  end
endmodule

/* test/test_read_error_plurality_check.sv */
`timescale 1ns/1ns

// self-checking bench for the read error classifier
module test_read_error_plurality_check;
  // stimulus and design outputs
  logic        clk, rstn, ren, hs, strb, stall, slow, locked, ce;
  logic [8:0]  tdata, terr, tq, tzd, tod, selo, dout;
  logic        cready, psub, locko, dvalid, dready, hardo, corro, tmif, tmcpu;
  // counters and model state
  int          marks_if, marks_cpu, failures, num_checks, exp_marks, lcnt, nread, k;
  logic [31:0] seed;
  logic [8:0]  dly_d [8];
  logic        dly_p [8];
  logic        dly_c [8];
  logic [8:0]  exp_q [$];

  rpc_top rpc_top_i (
    .CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .READ_ENABLE_IN_I(ren), .HIGH_SPEED_I(hs),
    .CHAR_STROBE_I(strb), .CHAR_READY_O(cready), .TRACK_DATA_I(tdata),
    .TRACK_ERROR_FLAG_I(terr), .TRACK_QUIET_I(tq), .ZERO_DETECT_I(tzd),
    .ONE_DETECT_I(tod), .PARITY_SUBSTITUTE_BIT_O(psub), .SUBSTITUTE_SELECT_O(selo),
    .LOCK_O(locko), .DATA_VALID_O(dvalid), .DATA_READY_I(dready), .DATA_O(dout),
    .HARD_ERROR_OUT_O(hardo), .CORRECTABLE_ERROR_OUT_O(corro),
    .TAPE_MARK_TO_INTERFACE_O(tmif), .TAPE_MARK_TO_CPU_O(tmcpu)
  );
  rpc_fmt_model rpc_fmt_model_i (
    .clk_i(clk), .rstn_i(rstn), .stall_i(stall), .slow_i(slow), .ready_o(dready),
    .tm_if_i(tmif), .tm_cpu_i(tmcpu), .marks_if_o(marks_if), .marks_cpu_o(marks_cpu)
  );

  // free-running clock, 8 ns period
  always #4 clk = ~clk;

  // next pseudo-random state
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one compare, counted
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // fresh read: locked, empty delay line
  task automatic clear_model();
    locked = 1'b1;
    lcnt = 0;
    nread = 0;
    exp_q.delete();
    for (int i = 0; i < 8; i++)
      {dly_d[i], dly_p[i], dly_c[i]} = 11'h000;
  endtask

  // one character, then the outputs after the edge that takes it
  task automatic send(input logic [8:0] d, e, q, zd, od);
    logic [8:0] c;
    logic       sgl, tm;
    int         n;
    n = 0;
    while (cready !== 1'b1 && n < 300)
    begin
      strb = 1'b0;
      @(negedge clk);
      n++;
    end
    {strb, tdata, terr, tq, tzd, tod} = {1'b1, d, e, q, zd, od};
    @(negedge clk);
    sgl = $countones(e) == 1;
    c = sgl ? (d & ~e) | ({9{~^(d & ~e)}} & e) : d;
    tm = (((d | q) & rpc_pkg::TM_ZERO_TRACKS) == 9'h000)
      && ((q | rpc_pkg::TM_ZERO_TRACKS) == 9'h1FF) && (&zd) && !(&od);
    exp_marks += tm;
    chk("select", (sgl && !locked) ? e : 9'h000, selo);
    if (sgl && !locked)
      chk("subst bit", ~^(d & ~e), psub);
    chk("hard", (!locked && $countones(e) > 1) || dly_p[7], hardo);
    chk("correctable", dly_c[7], corro);
    chk("mark if", tm, tmif);
    chk("mark cpu", tm, tmcpu);
    if (nread >= 8)
      exp_q.push_back(dly_d[7]);
    for (int i = 7; i > 0; i--)
      {dly_d[i], dly_p[i], dly_c[i]} = {dly_d[i-1], dly_p[i-1], dly_c[i-1]};
    {dly_d[0], dly_p[0], dly_c[0]} = {c, !locked && !sgl && !(^c), !locked && sgl};
    nread++;
    if (locked && $countones(e) < 2)
      lcnt++;
    if (lcnt == 8)
      locked = 1'b0;
    chk("lock", locked, locko);
  endtask

  // random character, multi errors kept at odd parity
  task automatic rnd_send();
    logic [8:0] d, e;
    seed = lfsr(seed);
    d = seed[8:0];
    e = seed[10] ? 9'h000 : 9'h001 << (seed[15:12] % 9);
    if (seed[11])
      e = e | (9'h001 << (seed[19:16] % 9));
    if ($countones(e) > 1)
      d[8] = ~^d[7:0];
    slow = seed[25];
    send(d, e, 9'h000, {9{seed[20]}}, {9{seed[21]}});
  endtask

  // drop strobe and wait
  task automatic idle(input int n);
    strb = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  // wait for the formatter to take every expected word
  task automatic drain();
    idle(1);
    for (int n = 0; n < 600 && exp_q.size() > 0; n++)
      @(negedge clk);
    chk("drained", 0, exp_q.size());
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // output words against the delayed corrected characters
  always @(posedge clk)
    if (rstn && dvalid === 1'b1 && dready === 1'b1)
      chk("word", exp_q.size() > 0 ? exp_q.pop_front() : ~dout, dout);

  // watchdog: whole run needs well under 6000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    {clk, rstn, ren, hs, strb, stall, slow} = 7'h00;
    ce = 1'b1;
    {tdata, terr, tq, tzd, tod} = 45'h0;
    {failures, num_checks, exp_marks} = 96'h0;
    seed = 32'hC128;
    clear_model();
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    ren = 1'b1;
    idle(2);
    send(9'h07F, 9'h003, 9'h000, 9'h000, 9'h000);
    repeat (8) send(9'h1FF, 9'h010, 9'h000, 9'h000, 9'h000);
    $display("test lock done");
    send(9'h1C0, 9'h100, 9'h000, 9'h000, 9'h000);
    send(9'h0A5, 9'h001, 9'h000, 9'h000, 9'h000);
    send(9'h07F, 9'h0C0, 9'h000, 9'h000, 9'h000);
    send(9'h003, 9'h000, 9'h000, 9'h000, 9'h000);
    send(9'h000, 9'h000, 9'h13B, 9'h1FF, 9'h000);
    hs = 1'b1;
    send(9'h000, 9'h000, 9'h13B, 9'h1FF, 9'h000);
    send(9'h000, 9'h000, 9'h13B, 9'h1FF, 9'h1FF);
    send(9'h000, 9'h000, 9'h13B, 9'h0FF, 9'h000);
    repeat (160) rnd_send();
    drain();
    $display("test corners and random done");
    // enable low: a strobed tape mark must leave no trace
    ce = 1'b0;
    {strb, tdata, terr, tq, tzd, tod} = {1'b1, 9'h000, 9'h000, 9'h13B, 9'h1FF, 9'h000};
    repeat (3) @(negedge clk);
    chk("frozen mark", 0, tmif);
    ce = 1'b1;
    idle(1);
    $display("test enable done");
    stall = 1'b1;
    for (k = 0; k < 40 && cready === 1'b1; k++)
      rnd_send();
    chk("fill refused", 1, k >= 31 && cready === 1'b0);
    stall = 1'b0;
    drain();
    $display("test buffer done");
    ren = 1'b0;
    idle(2);
    chk("lock after end", 1, locko);
    chk("valid after end", 0, dvalid);
    clear_model();
    ren = 1'b1;
    idle(2);
    repeat (30) rnd_send();
    drain();
    chk("marks if", exp_marks, marks_if);
    chk("marks cpu", exp_marks, marks_cpu);
    $display("test restart done");
    tally_and_finish();
  end
endmodule
